// File: design/plst_probe_latch_status.sv
// design: two-channel probe latch with status word and four latched positions
`timescale 1ns/1ps
`default_nettype none

module plst_probe_latch_status
  import plst_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // register port
  input  wire logic [17:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // trigger pins and index pulse
  input  wire logic        probe_input_one,
  input  wire logic        probe_input_two,
  input  wire logic        encoder_index_pulse,
  // live position to capture
  input  wire logic [31:0] position,
  // status mirror
  output logic      [15:0] probe_status_word
);

  // ************************************************************
  // control registers
  // ************************************************************
  plst_bus_req_t   req;
  logic [15:0]     ctrl;
  logic [7:0]      index_latch_config_setting;

  assign req = '{wr: wr, rd: rd, addr: addr, wdata: wdata};

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl <= PLST_CTRL_RST;
    end
    else if (req.wr && req.addr == PLST_ADDR_CTRL)
    begin
      ctrl <= req.wdata[15:0];
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      index_latch_config_setting <= PLST_CFG_RST;
    end
    else if (req.wr && req.addr == PLST_ADDR_CFG)
    begin
      index_latch_config_setting <= req.wdata[7:0];
    end
  end

  logic count_mode;
  assign count_mode = (index_latch_config_setting == PLST_CFG_COUNT_MODE);

  // ************************************************************
  // pin synchronisers: three stages, change taken when 2 and 3 agree
  // ************************************************************
  logic [2:0] pin_raw;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic [2:0] pin_level;

  assign pin_raw = {encoder_index_pulse, probe_input_two, probe_input_one};

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      sync3 <= 3'h0;
    end
    else
    begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // filtered level moves only when the last two stages agree
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_level <= 3'h0;
    end
    else
    begin
      for (int b = 0; b < 3; b++)
      begin
        if (sync2[b] == sync3[b])
        begin
          pin_level[b] <= sync3[b];
        end
      end
    end
  end

  // ************************************************************
  // per-probe capture
  // ************************************************************
  logic [3:0][31:0] pos_store;
  logic [1:0][7:0]  status_byte;

  genvar p;
  generate
    for (p = 0; p < 2; p++)
    begin : g_probe
      logic [7:0] cb;
      logic       trig;
      logic       trig_d;
      logic       rise;
      logic       fall;
      logic       rise_flag;
      logic       fall_flag;
      logic [1:0] exec_count;
      logic       cont;
      logic       arm_rise;
      logic       arm_fall;
      logic       take_rise;
      logic       take_fall;
      plst_src_t  src;
      logic [31:0] rise_pos;
      logic [31:0] fall_pos;
      logic [7:0]  sbyte;

      // each probe owns its own pair and byte, so every slot has one driver
      assign pos_store[2*p]   = rise_pos;
      assign pos_store[2*p+1] = fall_pos;
      assign status_byte[p]   = sbyte;
      assign cb       = ctrl[p*PLST_BYTE_W +: PLST_BYTE_W];
      assign cont     = cb[PLST_C_CONT];
      assign src      = cb[PLST_C_SRC] ? PLST_SRC_INDEX : PLST_SRC_INPUT;
      assign trig     = (src == PLST_SRC_INDEX) ? pin_level[2] : pin_level[p];
      assign rise     = trig && !trig_d;
      assign fall     = !trig && trig_d;
      // first-event mode takes one capture per edge kind until re-armed
      assign arm_rise = cb[PLST_C_ENABLE] && cb[PLST_C_RISE] && (cont || !rise_flag);
      assign arm_fall = cb[PLST_C_ENABLE] && cb[PLST_C_FALL] && (cont || !fall_flag);
      assign take_rise = arm_rise && rise;
      assign take_fall = arm_fall && fall;

      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          trig_d <= 1'b0;
        end
        else
        begin
          trig_d <= trig;
        end
      end

      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          rise_flag  <= 1'b0;
          fall_flag  <= 1'b0;
          exec_count <= 2'h0;
        end
        else if (!cb[PLST_C_ENABLE])
        begin
          rise_flag  <= 1'b0;
          fall_flag  <= 1'b0;
          exec_count <= 2'h0;
        end
        else
        begin
          if (take_rise)
          begin
            rise_flag <= 1'b1;
          end
          if (take_fall)
          begin
            fall_flag <= 1'b1;
          end
          if (take_rise || take_fall)
          begin
            exec_count <= exec_count + 2'h1;                        // wraps 3 -> 0
          end
        end
      end

      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          rise_pos <= PLST_POS_RST;
          fall_pos <= PLST_POS_RST;
        end
        else
        begin
          if (take_rise)
          begin
            rise_pos <= position;
          end
          if (take_fall)
          begin
            fall_pos <= position;
          end
        end
      end

      always_comb
      begin
        sbyte                = 8'h00;
        sbyte[PLST_S_ENABLE] = cb[PLST_C_ENABLE];
        sbyte[PLST_S_RISE]   = rise_flag;
        sbyte[PLST_S_FALL]   = fall_flag;
        if (count_mode)
        begin
          if (cont)
          begin
            sbyte[PLST_S_LEVEL:PLST_S_SRC] = exec_count;
          end
          else
          begin
            sbyte[PLST_S_LEVEL:PLST_S_SRC] = 2'h0;
          end
        end
        else
        begin
          sbyte[PLST_S_SRC]   = cb[PLST_C_SRC];
          sbyte[PLST_S_LEVEL] = pin_level[p];
        end
      end
    end
  endgenerate

  // ************************************************************
  // status word and read path
  // ************************************************************
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      probe_status_word <= 16'h0000;
    end
    else
    begin
      probe_status_word <= {status_byte[1], status_byte[0]};
    end
  end

  // position objects are read-only; writes to them are dropped
  logic [31:0] next_rdata;
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (req.addr >= PLST_ADDR_POS0 && req.addr <= PLST_ADDR_POS3 && req.addr[1:0] == 2'b00)
    begin
      next_rdata = pos_store[req.addr[3:2] - PLST_ADDR_POS0[3:2]];
    end
    else if (req.addr == PLST_ADDR_STATUS)
    begin
      next_rdata = {16'h0000, status_byte[1], status_byte[0]};
    end
    else if (req.addr == PLST_ADDR_CTRL)
    begin
      next_rdata = {16'h0000, ctrl};
    end
    else if (req.addr == PLST_ADDR_CFG)
    begin
      next_rdata = {24'h000000, index_latch_config_setting};
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata <= 32'h0000_0000;
    end
    else if (req.rd)
    begin
      rdata <= next_rdata;
    end
    else
    begin
      rdata <= 32'h0000_0000;
    end
  end

endmodule

`default_nettype wire

// File: shared/plst_pkg.sv
// package: register map, control bit positions and types for the probe latch status block
package plst_pkg;

  // ************************************************************
  // register map (indices; byte address is four times the index)
  // ************************************************************
  localparam logic [15:0] PLST_IDX_CTRL   = 16'h60B8;
  localparam logic [15:0] PLST_IDX_STATUS = 16'h60B9;
  localparam logic [15:0] PLST_IDX_POS_P1R = 16'h60BA;
  localparam logic [15:0] PLST_IDX_POS_P1F = 16'h60BB;
  localparam logic [15:0] PLST_IDX_POS_P2R = 16'h60BC;
  localparam logic [15:0] PLST_IDX_POS_P2F = 16'h60BD;
  localparam logic [15:0] PLST_IDX_CFG    = 16'h200C;
  localparam logic [17:0] PLST_ADDR_CTRL   = {PLST_IDX_CTRL, 2'b00};
  localparam logic [17:0] PLST_ADDR_STATUS = {PLST_IDX_STATUS, 2'b00};
  localparam logic [17:0] PLST_ADDR_POS0   = {PLST_IDX_POS_P1R, 2'b00};
  localparam logic [17:0] PLST_ADDR_POS3   = {PLST_IDX_POS_P2F, 2'b00};
  localparam logic [17:0] PLST_ADDR_CFG    = {PLST_IDX_CFG, 2'b00};

  // ************************************************************
  // field positions within one probe's control / status byte
  // ************************************************************
  localparam int PLST_BYTE_W      = 8;
  localparam int PLST_C_ENABLE    = 0;
  localparam int PLST_C_CONT      = 1;
  localparam int PLST_C_SRC       = 2;
  localparam int PLST_C_RISE      = 4;
  localparam int PLST_C_FALL      = 5;
  localparam int PLST_S_ENABLE    = 0;
  localparam int PLST_S_RISE      = 1;
  localparam int PLST_S_FALL      = 2;
  localparam int PLST_S_SRC       = 6;
  localparam int PLST_S_LEVEL     = 7;

  // ************************************************************
  // reset values and constants
  // ************************************************************
  localparam logic [15:0] PLST_CTRL_RST = 16'h0000;
  localparam logic [7:0]  PLST_CFG_RST  = 8'h00;
  localparam logic [7:0]  PLST_CFG_COUNT_MODE = 8'h02;
  localparam logic [31:0] PLST_POS_RST  = 32'h0000_0000;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [17:0] addr;
    logic [31:0] wdata;
  } plst_bus_req_t;

  typedef enum logic [1:0] {
    PLST_SRC_INPUT = 2'b01,
    PLST_SRC_INDEX = 2'b10
  } plst_src_t;

endpackage

// File: testbench/plst_host_model.sv
// partner: host controller on the register port
`timescale 1ns/1ps
`default_nettype none
module plst_host_model
  import plst_pkg::*;
(
  // clock
  input  wire logic        clk,
  // register port
  output logic      [17:0] addr,
  output logic      [31:0] wdata,
  output logic             wr,
  output logic             rd,
  input  wire logic [31:0] rdata
);
  int unsigned total;
  logic [1:0]  last_cnt;
  initial
  begin
    addr     = 18'h00000;
    wdata    = 32'h0000_0000;
    wr       = 1'b0;
    rd       = 1'b0;
    total    = 0;
    last_cnt = 2'h0;
  end
  // control, config and status are written, pins never forced
  task automatic write_reg(input logic [17:0] a, input logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic read_reg(input logic [17:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  // count wraps at 4, so the host sums the steps
  task automatic tally(input logic [1:0] c);
    total    = total + 32'(2'(c - last_cnt));
    last_cnt = c;
  endtask
endmodule
`default_nettype wire

// File: testbench/plst_monitor.sv
// checker: status word and read port relations of the probe latch
`timescale 1ns/1ps
`default_nettype none
module plst_monitor
  import plst_pkg::*;
(
  // clock, reset, register port
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [17:0] addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  // pins, position, status
  input wire logic        probe_input_one,
  input wire logic        probe_input_two,
  input wire logic        encoder_index_pulse,
  input wire logic [31:0] position,
  input wire logic [15:0] probe_status_word
);
  logic [15:0] ctrl;
  logic        cmode;
  // shadows rebuilt from writes, not read back through the block's ctrl and config registers
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      ctrl <= 16'h0000;
    else if (wr && addr == PLST_ADDR_CTRL)
      ctrl <= wdata[15:0];
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      cmode <= 1'b0;
    else if (wr && addr == PLST_ADDR_CFG)
      cmode <= wdata[7:0] == PLST_CFG_COUNT_MODE;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_rdata_idle: assert property (!rd |=> rdata == 32'h0)
    else $error("read data not idle");
  a_status_read: assert property (rd && addr == PLST_ADDR_STATUS |=>
    rdata == {16'h0000, probe_status_word}) else $error("status read differs");
  a_gap_zero: assert property (probe_status_word[5:3] == 3'h0 &&
    probe_status_word[13:11] == 3'h0) else $error("unused bits set");
  a_enable_mirror: assert property ($stable(ctrl)[*3] |->
    probe_status_word[0] == ctrl[0] && probe_status_word[8] == ctrl[8])
    else $error("enable bit wrong");
  a_level_mirror: assert property (
    (!cmode && $stable(probe_input_one) && $stable(probe_input_two))[*8] |->
    probe_status_word[7] == probe_input_one && probe_status_word[15] == probe_input_two)
    else $error("level bit wrong");
  a_source_mirror: assert property ((!cmode && $stable(ctrl))[*3] |->
    probe_status_word[6] == ctrl[2] && probe_status_word[14] == ctrl[10])
    else $error("source bit wrong");
  a_first_blank: assert property ((cmode && !ctrl[1] && $stable(ctrl))[*3] |->
    probe_status_word[7:6] == 2'h0) else $error("count in first event");
  a_off_clears: assert property ((!ctrl[0])[*3] |->
    probe_status_word[2:1] == 2'h0) else $error("flags kept when off");
  a_rise_armed: assert property ($rose(probe_status_word[1]) |->
    ctrl[0] && ctrl[4]) else $error("unarmed rise flag");
endmodule
bind plst_probe_latch_status plst_monitor plst_monitor_i (.clk, .resetn, .addr, .wdata,
  .wr, .rd, .rdata, .probe_input_one, .probe_input_two, .encoder_index_pulse, .position,
  .probe_status_word);
`default_nettype wire

// File: testbench/tb_top.sv
// testbench: scenarios for the probe latch status block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    compares++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("wrong value %0t %h %h", $time, g, e); \
    end \
  end
module tb_top
  import plst_pkg::*;
;
  logic        clk;
  logic        resetn;
  logic [2:0]  pin;
  logic [31:0] position;
  logic [17:0] addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic [31:0] d;
  logic [15:0] status_word;
  int          n_errors;
  int          compares;
  plst_host_model plst_host_model_i (.clk, .addr, .wdata, .wr, .rd, .rdata);
  plst_probe_latch_status plst_probe_latch_status_i (.clk, .resetn, .addr, .wdata, .wr,
    .rd, .rdata, .probe_input_one(pin[0]), .probe_input_two(pin[1]),
    .encoder_index_pulse(pin[2]), .position, .probe_status_word(status_word));
  task automatic wr_r(input logic [17:0] a, input logic [31:0] v);
    plst_host_model_i.write_reg(a, v);
  endtask
  task automatic rd_chk(input logic [17:0] a, input logic [31:0] e);
    plst_host_model_i.read_reg(a, d);
    `CHK(d, e)
  endtask
  task automatic st(input logic [15:0] e);
    rd_chk(PLST_ADDR_STATUS, {16'h0000, e});
    `CHK(status_word, e)
  endtask
  // pulses held 8 cycles, well over the filter width
  task automatic pulse(input int k, input logic [31:0] a, input logic [31:0] b);
    @(posedge clk);
    position <= a;
    pin[k]   <= 1'b1;
    repeat (8) @(posedge clk);
    position <= b;
    pin[k]   <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic t_edges();
    logic [31:0] pe [4];
    pe = '{32'h1111_0001, 32'h2222_0002, 32'h3333_0003, 32'h4444_0004};
    wr_r(PLST_ADDR_CTRL, 32'h0000_3333);
    pulse(0, pe[0], pe[1]);
    st(16'h0107);
    pulse(1, pe[2], pe[3]);
    wr_r(PLST_ADDR_STATUS, 32'h0000_0000);
    st(16'h0707);
    for (int k = 0; k < 4; k++)
      rd_chk(PLST_ADDR_POS0 + 18'(4 * k), pe[k]);
    wr_r(PLST_ADDR_CTRL, 32'h0000_0000);
    st(16'h0000);
    wr_r(PLST_ADDR_CTRL, 32'h0000_3333);
    st(16'h0101);
  endtask
  task automatic t_count();
    wr_r(PLST_ADDR_CFG, 32'h0000_0002);
    pulse(0, 32'h0000_0005, 32'h0000_0006);
    st(16'h0187);
    plst_host_model_i.tally(d[7:6]);
    pulse(0, 32'h0000_0007, 32'h0000_0008);
    st(16'h0107);
    plst_host_model_i.tally(d[7:6]);
    `CHK(plst_host_model_i.total, 4)
    wr_r(PLST_ADDR_CTRL, 32'h0000_3331);
    pin[0] <= 1'b1;
    repeat (8) @(posedge clk);
    st(16'h0107);
    wr_r(PLST_ADDR_CFG, 32'h0000_0000);
    st(16'h0187);
    @(posedge clk);
    pin[0] <= 1'b0;
  endtask
  task automatic t_source();
    wr_r(PLST_ADDR_CTRL, 32'h0000_0000);
    wr_r(PLST_ADDR_CTRL, 32'h0000_0015);
    pulse(0, 32'h0000_0007, 32'h0000_0008);
    st(16'h0041);
    pulse(2, 32'h0000_0009, 32'h0000_000A);
    st(16'h0043);
    rd_chk(PLST_ADDR_POS0, 32'h0000_0009);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    final_report();
  end
  initial
  begin
    resetn   = 1'b0;
    pin      = 3'h0;
    position = 32'h0000_0000;
    n_errors = 0;
    compares = 0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    st(16'h0000);
    rd_chk(PLST_ADDR_POS0, 32'h0000_0000);
    rd_chk(18'h00000, 32'h0000_0000);
    wr_r(PLST_ADDR_CTRL, 32'h0000_0101);
    pin[1:0] <= 2'b11;
    repeat (8) @(posedge clk);
    st(16'h8181);
    @(posedge clk);
    pin[1:0] <= 2'b00;
    repeat (8) @(posedge clk);
    t_edges();
    t_count();
    t_source();
    final_report();
  end
endmodule
`default_nettype wire
